// File: serial_input_and_dac_load_control.sv
// Serial input port, readback shifter and output-load control for four channels.
// Assumes serial clock idles low, host launches on rising and device samples on falling.
`timescale 1ns/1ps
module serial_input_and_dac_load_control
	import sdac_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic sclk_i,
	input wire logic sync_n_i,
	input wire logic serial_in_i,
	output logic serial_out_o,
	output logic serial_out_oe_o,
	input wire logic load_outputs_n_i,
	input wire logic board_addr_bit_lo_i,
	input wire logic board_addr_bit_hi_i,
	input wire logic packet_error_check_i,
	input wire logic clear_i,
	input wire logic open_circuit_i,
	input wire logic overtemp_i,
	input wire logic update_ready_i,
	output logic fault_n_o,
	output logic fault_oe_o,
	output code_bank_type out_code_o,
	output code_bank_type in_code_o
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [7:0] crc8(input logic [FRAME_BITS-1:0] w);
		logic [7:0] c;
		c = CRC_INIT;
		for (int i = FRAME_BITS - 1; i >= 0; i--) begin
			if (c[7] ^ w[i]) begin
				c = {c[6:0], 1'b0} ^ CRC_POLY;
			end else begin
				c = {c[6:0], 1'b0};
			end
		end
		return c;
	endfunction

	// ----------------------------------------
	// Link domain (serial clock, up to 30 MHz)
	// ----------------------------------------
	logic [FRAME_PEC_BITS-1:0] shift_reg;
	logic [CNT_W-1:0] bit_cnt_reg;
	logic active_reg;
	logic so_reg;
	logic [FRAME_BITS-1:0] rb_reg;
	logic [CNT_W-1:0] rb_idx;

	always_ff @(negedge sclk_i) begin
		if (!sync_n_i) begin
			shift_reg <= {shift_reg[FRAME_PEC_BITS-2:0], serial_in_i};
		end
	end

	always_ff @(negedge sclk_i or posedge sync_n_i) begin
		if (sync_n_i) begin
			active_reg <= 1'b0;
		end else begin
			active_reg <= 1'b1;
		end
	end

	always_ff @(negedge sclk_i) begin
		if (!sync_n_i) begin
			if (!active_reg) begin
				bit_cnt_reg <= 6'h01;
			end else if (bit_cnt_reg != CNT_MAX) begin
				bit_cnt_reg <= bit_cnt_reg + 6'h01;
			end
		end
	end

	assign rb_idx = active_reg ? bit_cnt_reg : 6'h00;

	always_ff @(posedge sclk_i or posedge sync_n_i) begin
		if (sync_n_i) begin
			so_reg <= 1'b0;
		end else if (rb_idx < LEN_PLAIN) begin
			so_reg <= rb_reg[5'(FRAME_BITS - 1) - rb_idx[4:0]];
		end else begin
			so_reg <= 1'b0;
		end
	end

	assign serial_out_o = so_reg;
	assign serial_out_oe_o = !sync_n_i;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [1:0] sync_n_meta_reg, load_meta_reg, clr_meta_reg, pec_meta_reg;
	logic [1:0] addr_meta_reg, addr_reg;
	logic sync_s_reg, sync_d_reg, load_s_reg, load_d_reg, clr_s_reg, pec_s_reg;

	always_ff @(posedge clk_sys_i) begin
		sync_n_meta_reg <= {sync_n_meta_reg[0], sync_n_i};
		load_meta_reg <= {load_meta_reg[0], load_outputs_n_i};
		clr_meta_reg <= {clr_meta_reg[0], clear_i};
		pec_meta_reg <= {pec_meta_reg[0], packet_error_check_i};
		addr_meta_reg <= {board_addr_bit_hi_i, board_addr_bit_lo_i};
		addr_reg <= addr_meta_reg;
		sync_s_reg <= sync_n_meta_reg[1];
		load_s_reg <= load_meta_reg[1];
		clr_s_reg <= clr_meta_reg[1];
		pec_s_reg <= pec_meta_reg[1];
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			sync_d_reg <= 1'b1;
			load_d_reg <= load_s_reg;
		end else begin
			sync_d_reg <= sync_s_reg;
			load_d_reg <= load_s_reg;
		end
	end

	// ----------------------------------------
	// Frame decode at frame sync rising edge
	// ----------------------------------------
	logic frame_rise, len_ok, crc_ok, frame_ok, pec_fail, load_fall;
	logic [FRAME_BITS-1:0] word;

	assign frame_rise = sync_s_reg && !sync_d_reg && (bit_cnt_reg != 6'h00);
	assign len_ok = bit_cnt_reg == (pec_s_reg ? LEN_PEC : LEN_PLAIN);
	assign word = pec_s_reg ? shift_reg[FRAME_PEC_BITS-1:PEC_BITS] : shift_reg[FRAME_BITS-1:0];
	assign crc_ok = !pec_s_reg || (crc8(word) == shift_reg[PEC_BITS-1:0]);
	assign frame_ok = frame_rise && len_ok && crc_ok && (word[ADDR_HI:ADDR_LO] == addr_reg);
	assign pec_fail = frame_rise && pec_s_reg && !(len_ok && crc_ok);
	assign load_fall = load_d_reg && !load_s_reg;

	// ----------------------------------------
	// Pending command and two-entry buffer
	// ----------------------------------------
	dac_cmd_type pend_reg;
	logic pend_valid_reg;
	dac_cmd_type fifo_mem [FIFO_DEPTH];
	logic wr_ptr_reg, rd_ptr_reg;
	logic [1:0] fill_reg;
	logic fifo_full, fifo_empty, push, pop;

	assign fifo_full = fill_reg == 2'(FIFO_DEPTH);
	assign fifo_empty = fill_reg == 2'h0;
	assign push = pend_valid_reg && !fifo_full;
	assign pop = !fifo_empty && update_ready_i;

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			pend_valid_reg <= 1'b0;
			pend_reg <= '0;
		end else if (frame_ok && !word[RD_BIT] && (!pend_valid_reg || push)) begin
			pend_valid_reg <= 1'b1;
			pend_reg <= '{ch: word[CH_HI:CH_LO], code: word[CODE_HI:CODE_LO]};
		end else if (push) begin
			pend_valid_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			fill_reg <= 2'h0;
		end else begin
			if (push) begin
				fifo_mem[wr_ptr_reg] <= pend_reg;
				wr_ptr_reg <= !wr_ptr_reg;
			end
			if (pop) begin
				rd_ptr_reg <= !rd_ptr_reg;
			end
			fill_reg <= fill_reg + 2'(push) - 2'(pop);
		end
	end

	// ----------------------------------------
	// Input and output data registers
	// ----------------------------------------
	code_bank_type in_reg, in_next, out_reg, out_next;
	dac_cmd_type head;

	assign head = fifo_mem[rd_ptr_reg];

	always_comb begin
		in_next = in_reg;
		out_next = out_reg;
		if (pop) begin
			in_next[head.ch] = head.code;
		end
		if (!clr_s_reg) begin
			if (load_fall) begin
				out_next = in_next;
			end else if (pop && !load_s_reg) begin
				out_next[head.ch] = head.code;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			in_reg <= '{default: CODE_RESET};
			out_reg <= '{default: CODE_RESET};
		end else begin
			in_reg <= in_next;
			out_reg <= out_next;
		end
	end

	assign in_code_o = in_reg;
	assign out_code_o = out_reg;

	// ----------------------------------------
	// Readback word and fault output
	// ----------------------------------------
	logic pec_err_reg, fault_reg;

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			rb_reg <= '0;
		end else if (frame_ok && word[RD_BIT]) begin
			rb_reg <= {1'b0, addr_reg, 3'h0, word[CH_HI:CH_LO], 4'h0, out_reg[word[CH_HI:CH_LO]]};
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			pec_err_reg <= 1'b0;
			fault_reg <= 1'b0;
		end else begin
			pec_err_reg <= pec_err_reg || pec_fail;
			fault_reg <= pec_err_reg || open_circuit_i || overtemp_i;
		end
	end

	assign fault_n_o = 1'b0;
	assign fault_oe_o = fault_reg;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_fault_cause: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(open_circuit_i || overtemp_i) |=> fault_oe_o && !fault_n_o)
		else $error("fault not raised on cause");
	a_pec_sticky: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		pec_fail |=> pec_err_reg ##1 fault_oe_o [*3])
		else $error("check failure not held on fault");
	a_clear_blocks: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		clr_s_reg |=> $stable(out_code_o))
		else $error("output written during clear");
	a_load_all: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		load_fall && !clr_s_reg && !pop |=> out_code_o == $past(in_code_o))
		else $error("load edge did not update all outputs");
	a_hold_high: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		load_s_reg && !load_fall |=> $stable(out_code_o))
		else $error("output changed with load high");
	a_imm_update: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		pop && !load_s_reg && !clr_s_reg && !load_fall
		|=> out_code_o[$past(head.ch)] == $past(head.code))
		else $error("output not updated at frame end");
	a_addr_match: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		frame_ok |-> word[ADDR_HI:ADDR_LO] == {board_addr_bit_hi_i, board_addr_bit_lo_i}
		|| $changed(addr_reg))
		else $error("frame accepted for other address");
	a_shift_in: assert property (@(negedge sclk_i) disable iff (sync_n_i)
		1'b1 |=> shift_reg[0] == $past(serial_in_i))
		else $error("serial input bit not shifted");
	a_shift_out: assert property (@(posedge sclk_i) disable iff (sync_n_i)
		rb_idx == 6'h00 |=> serial_out_o == $past(rb_reg[FRAME_BITS-1]))
		else $error("readback first bit wrong");

	c_write_frame: cover property (@(posedge clk_sys_i) frame_ok && !word[RD_BIT]);
	c_read_frame: cover property (@(posedge clk_sys_i) frame_ok && word[RD_BIT]);
	c_fifo_full: cover property (@(posedge clk_sys_i) fifo_full && pend_valid_reg);
	c_load_edge: cover property (@(posedge clk_sys_i) load_fall && !clr_s_reg);

endmodule

// File: sdac_pkg.sv
// Constants and types for the serial input and output-load control block.
// Assumes one system clock domain plus the host serial clock as link domain.
//
// Overview of operation
// - With frame sync low, serial input bits shift in on falling serial clock edges.
// - Serial link works up to 30 MHz; host keeps serial clock at or below it.
// - Readback frame contents shift out on serial output, clocked by serial clock.
// - Load input held low: addressed output register updates at frame end.
// - Load input high: only input register updates; falling load edge updates all.
// - Board address pins decode which device on the bus a frame addresses.
// - While clear is active, writes to output data registers are blocked.
// - Fault output goes low on check failure, open circuit or overtemperature.
package sdac_pkg;

	// ----------------------------------------
	// Frame layout
	// ----------------------------------------
	localparam int FRAME_BITS = 24;
	localparam int PEC_BITS = 8;
	localparam int FRAME_PEC_BITS = FRAME_BITS + PEC_BITS;
	localparam int CNT_W = 6;
	localparam logic [CNT_W-1:0] CNT_MAX = 6'h3F;
	localparam logic [CNT_W-1:0] LEN_PLAIN = 6'h18;
	localparam logic [CNT_W-1:0] LEN_PEC = 6'h20;
	localparam int RD_BIT = 23;
	localparam int ADDR_HI = 22;
	localparam int ADDR_LO = 21;
	localparam int CH_HI = 17;
	localparam int CH_LO = 16;
	localparam int CODE_HI = 11;
	localparam int CODE_LO = 0;
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] CRC_INIT = 8'h00;

	// ----------------------------------------
	// Channels and timing
	// ----------------------------------------
	localparam int CHANNELS = 4;
	localparam int CODE_W = 12;
	localparam logic [CODE_W-1:0] CODE_RESET = 12'h000;
	localparam int SCLK_MAX_HZ = 30_000_000;
	localparam int SYS_CLK_HZ = 40_000_000;
	localparam int FIFO_DEPTH = 2;

	typedef struct packed {
		logic [1:0] ch;
		logic [CODE_W-1:0] code;
	} dac_cmd_type;

	typedef logic [CHANNELS-1:0][CODE_W-1:0] code_bank_type;

endpackage

// File: sdac_host_model.sv
// Host model: drives frames on the serial link and collects readback bits.
// Assumes the device samples on falling and drives serial_out on rising clock.
`timescale 1ns/1ps
module sdac_host_model (
	output logic sclk_o,
	output logic sync_n_o,
	output logic serial_in_o,
	input wire logic serial_out_i
);
	initial begin
		sclk_o = 1'h0;
		sync_n_o = 1'h1;
		serial_in_o = 1'h1;
	end
	// 80 ns link period; one stray clock pulse after sync rise must be ignored
	task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] rd);
		rd = '0;
		sync_n_o = 1'h0;
		#40;
		for (int i = n - 1; i >= 0; i--) begin
			sclk_o = 1'h1;
			serial_in_o = w[i];
			#40;
			rd = {rd[30:0], serial_out_i};
			sclk_o = 1'h0;
			#40;
		end
		sync_n_o = 1'h1;
		serial_in_o = ~serial_in_o;
		#5;
		sclk_o = 1'h1;
		#20;
		sclk_o = 1'h0;
		#175;
	endtask
endmodule

// File: testbench.sv
// Testbench: table of writes, then load, address, clear, stall, readback, fault, reset.
// Assumes the package and the host model are compiled first.
`timescale 1ns/1ps
module testbench;
	import sdac_pkg::*;
	typedef struct packed {
		logic [1:0] ch;
		logic [11:0] code;
		logic ld_n;
		logic [11:0] exp_out;
	} row_type;
	logic clk = 1'h0, rst = 1'h1, ld_n = 1'h0, clr = 1'h0, oc = 1'h0, ot = 1'h0;
	logic packet_error_check = 1'h0, rdy = 1'h1;
	logic sclk, sync_n, sdi, serial_out, sdo_oe, flt_n, flt_oe;
	code_bank_type outs, ins;
	logic [31:0] rd;
	logic [23:0] w24;
	int n_fail = 0, n_checks = 0, cyc = 0;
	row_type rows[4] = '{'{2'h0, 12'hA5C, 1'h0, 12'hA5C}, '{2'h3, 12'hFFF, 1'h0, 12'hFFF},
		'{2'h1, 12'h001, 1'h0, 12'h001}, '{2'h2, 12'h800, 1'h1, 12'h000}};
	wire flt_pin = flt_oe ? flt_n : 1'h1;
	wire sdo_w = sdo_oe ? serial_out : ~sdi;
	sdac_host_model host (.sclk_o(sclk), .sync_n_o(sync_n), .serial_in_o(sdi),
		.serial_out_i(sdo_w));
	// Board address 2'h2, never both straps low with checking on
	serial_input_and_dac_load_control DUT (.clk_sys_i(clk), .sys_rst_i(rst),
		.sclk_i(sclk), .sync_n_i(sync_n), .serial_in_i(sdi), .serial_out_o(serial_out),
		.serial_out_oe_o(sdo_oe), .load_outputs_n_i(ld_n), .board_addr_bit_lo_i(1'h0),
		.board_addr_bit_hi_i(1'h1), .packet_error_check_i(packet_error_check), .clear_i(clr),
		.open_circuit_i(oc), .overtemp_i(ot), .update_ready_i(rdy), .fault_n_o(flt_n),
		.fault_oe_o(flt_oe), .out_code_o(outs), .in_code_o(ins));
	initial begin
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			final_report();
		end
	end
	task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
		#1;
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	function automatic logic [7:0] crc_of(input logic [23:0] w);
		logic [7:0] c;
		c = CRC_INIT;
		for (int i = 23; i >= 0; i--) begin
			c = {c[6:0], 1'h0} ^ ((c[7] ^ w[i]) ? CRC_POLY : 8'h00);
		end
		return c;
	endfunction
	task automatic frame(input logic r, input logic [1:0] ad, input logic [1:0] ch,
		input logic [11:0] code);
		host.xfer({8'h0, r, ad, 3'h0, ch, 4'h0, code}, 24, rd);
		repeat (16) @(posedge clk);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'h0;
		repeat (6) @(posedge clk);
		foreach (rows[i]) begin
			@(posedge clk) ld_n <= rows[i].ld_n;
			frame(1'h0, 2'h2, rows[i].ch, rows[i].code);
			chk({ins[rows[i].ch], outs[rows[i].ch]}, {rows[i].code, rows[i].exp_out});
		end
		$display("test table done");
		@(posedge clk) ld_n <= 1'h0;
		repeat (6) @(posedge clk);
		chk(outs, {12'hFFF, 12'h800, 12'h001, 12'hA5C});
		frame(1'h0, 2'h1, 2'h0, 12'h123);
		chk(ins[0], 12'hA5C);
		$display("test load and address done");
		@(posedge clk) clr <= 1'h1;
		frame(1'h0, 2'h2, 2'h1, 12'h456);
		chk({ins[1], outs[1]}, {12'h456, 12'h001});
		@(posedge clk) clr <= 1'h0;
		rdy <= 1'h0;
		frame(1'h0, 2'h2, 2'h0, 12'h111);
		frame(1'h0, 2'h2, 2'h3, 12'h222);
		frame(1'h0, 2'h2, 2'h1, 12'h0AB);
		frame(1'h0, 2'h2, 2'h2, 12'h0CD);
		chk(outs[0], 12'hA5C);
		@(posedge clk) rdy <= 1'h1;
		repeat (8) @(posedge clk);
		chk(outs, {12'h222, 12'h800, 12'h0AB, 12'h111});
		$display("test clear and stall done");
		frame(1'h1, 2'h2, 2'h3, 12'h000);
		frame(1'h1, 2'h2, 2'h3, 12'h000);
		chk(rd[23:0], {1'h0, 2'h2, 3'h0, 2'h3, 4'h0, 12'h222});
		for (int k = 0; k < 2; k++) begin
			@(posedge clk) {oc, ot} <= 2'h1 << k;
			repeat (3) @(posedge clk);
			chk(flt_pin, 1'h0);
			@(posedge clk) {oc, ot} <= 2'h0;
			repeat (3) @(posedge clk);
			chk(flt_pin, 1'h1);
		end
		@(posedge clk) packet_error_check <= 1'h1;
		repeat (4) @(posedge clk);
		frame(1'h0, 2'h2, 2'h0, 12'h333);
		chk({flt_pin, ins[0]}, {1'h0, 12'h111});
		w24 = {1'h0, 2'h2, 3'h0, 2'h0, 4'h0, 12'h333};
		host.xfer({w24, crc_of(w24)}, 32, rd);
		repeat (16) @(posedge clk);
		chk({flt_pin, ins[0], outs[0]}, {1'h0, 12'h333, 12'h333});
		$display("test readback and fault done");
		@(posedge clk) rst <= 1'h1;
		repeat (10) @(posedge clk);
		chk({flt_pin, outs, ins}, {1'h1, 96'h0});
		rst <= 1'h0;
		$display("test reset done");
		final_report();
	end
endmodule
